// ===== verilog/program_sequencer_stack.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module program_sequencer_stack (
    input  wire logic                                 clk_in,
    input  wire logic                                 rstn_in,
    input  wire logic [`WORD_W-1:0]                   prog_data_in,
    input  wire logic                                 timer_irq_in,
    input  wire logic                                 int_enable_in,
    output logic      [`PC_W-1:0]                     prog_addr_out,
    output program_sequencer_pkg::cycle_phases_t      cycle_phases_out,
    output logic      [`DATA_W-1:0]                   acc_out,
    output program_sequencer_pkg::status_t            status_out,
    output logic                                      dummy_cycle_out,
    output logic                                      irq_pending_out,
    output logic                                      int_ack_out,
    output logic                                      stack_full_out
);

    // ==========================================================
    // Declarations
    program_sequencer_pkg::cycle_phases_t phase_r;
    program_sequencer_pkg::cycle_phases_t phase_nxt;
    program_sequencer_pkg::status_t       status_r;
    program_sequencer_pkg::status_t       status_nxt;
    program_sequencer_pkg::instr_fields_t exec;

    logic [`PC_W-1:0]   pc_r;
    logic [`PC_W-1:0]   pc_nxt;
    logic [`WORD_W-1:0] fetch_r;
    logic [`WORD_W-1:0] exec_word_r;
    logic               exec_valid_r;
    logic               exec_valid_nxt;
    logic [`DATA_W-1:0] acc_r;
    logic [`DATA_W-1:0] acc_nxt;
    logic               irq_flag_r;
    logic               int_ack_r;
    logic               commit;
    logic               ack;
    logic               push;
    logic               pop;
    logic [`PC_W-1:0]   stack_top;
    logic               stack_full;

    // ==========================================================
    // Instruction word split into fields
    function automatic program_sequencer_pkg::instr_fields_t decode_word(
        input logic [`WORD_W-1:0] w
    );
        program_sequencer_pkg::instr_fields_t f;
        f.cls    = program_sequencer_pkg::instr_class_t'(w[`F_CLS_HI:`F_CLS_LO]);
        f.sub    = w[`F_SUB_HI:`F_SUB_LO];
        f.imm    = w[`F_IMM_HI:`F_IMM_LO];
        f.target = w[`F_TGT_HI:`F_TGT_LO];
        return f;
    endfunction

    // ==========================================================
    // Eight-bit ALU: returns new status and result together
    function automatic logic [`DATA_W+1:0] alu_calc(
        input logic [2:0]         op,
        input logic [`DATA_W-1:0] a,
        input logic [`DATA_W-1:0] b,
        input logic               cin
    );
        logic [`DATA_W:0]   wide;
        logic [`DATA_W-1:0] res;
        logic               cout;
        wide = {1'b0, `DATA_ZERO};
        res  = `DATA_ZERO;
        cout = cin;
        unique case (program_sequencer_pkg::alu_op_t'(op))
            program_sequencer_pkg::ALU_ADD: begin
                wide = {1'b0, a} + {1'b0, b};
                res  = wide[`DATA_W-1:0];
                cout = wide[`DATA_W];
            end
            program_sequencer_pkg::ALU_SUB: begin
                wide = {1'b0, a} - {1'b0, b};
                res  = wide[`DATA_W-1:0];
                cout = ~wide[`DATA_W];
            end
            program_sequencer_pkg::ALU_AND: begin
                res = a & b;
            end
            program_sequencer_pkg::ALU_OR: begin
                res = a | b;
            end
            program_sequencer_pkg::ALU_XOR: begin
                res = a ^ b;
            end
            program_sequencer_pkg::ALU_RLC: begin
                res  = {a[`DATA_MSB-1:0], cin};
                cout = a[`DATA_MSB];
            end
            program_sequencer_pkg::ALU_INC: begin
                res = a + `DATA_ONE;
            end
            program_sequencer_pkg::ALU_DEC: begin
                res = a - `DATA_ONE;
            end
        endcase
        return {cout, (res == `DATA_ZERO), res};
    endfunction

    // ==========================================================
    // Phase sequencer
    always_comb begin
        unique case (phase_r)
            program_sequencer_pkg::PH_T1: phase_nxt = program_sequencer_pkg::PH_T2;
            program_sequencer_pkg::PH_T2: phase_nxt = program_sequencer_pkg::PH_T3;
            program_sequencer_pkg::PH_T3: phase_nxt = program_sequencer_pkg::PH_T4;
            program_sequencer_pkg::PH_T4: phase_nxt = program_sequencer_pkg::PH_T1;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            phase_r <= program_sequencer_pkg::PH_T1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Execution results take effect at the end of the last phase
    assign commit = (phase_r == program_sequencer_pkg::PH_T4);

    // ==========================================================
    // Execute stage: next counter, flow changes, ALU results
    always_comb begin
        logic [`DATA_W+1:0] alu_out;
        alu_out        = alu_calc(3'b000, `DATA_ZERO, `DATA_ZERO, 1'b0);
        exec           = decode_word(exec_word_r);
        pc_nxt         = pc_r + `PC_ONE;
        exec_valid_nxt = 1'b1;
        acc_nxt        = acc_r;
        status_nxt     = status_r;
        push           = 1'b0;
        pop            = 1'b0;
        ack            = 1'b0;
        if (exec_valid_r) begin
            unique case (exec.cls)
                program_sequencer_pkg::CLS_ALU: begin
                    alu_out    = alu_calc(exec.sub, acc_r, exec.imm,
                                          status_r.carry);
                    acc_nxt    = alu_out[`DATA_W-1:0];
                    status_nxt = alu_out[`DATA_W+1:`DATA_W];
                end
                program_sequencer_pkg::CLS_MISC: begin
                    unique case (program_sequencer_pkg::misc_op_t'(exec.sub))
                        program_sequencer_pkg::MISC_NOP: begin
                            acc_nxt = acc_r;
                        end
                        program_sequencer_pkg::MISC_SUB_RETURN,
                        program_sequencer_pkg::MISC_INT_RETURN: begin
                            pop            = 1'b1;
                            pc_nxt         = stack_top;
                            exec_valid_nxt = 1'b0;
                        end
                        program_sequencer_pkg::MISC_WR_PCL: begin
                            pc_nxt = {pc_r[`PC_PAGE_HI:`PC_PAGE_LO],
                                      acc_r};
                            exec_valid_nxt = 1'b0;
                        end
                        program_sequencer_pkg::MISC_RD_PCL: begin
                            acc_nxt = pc_r[`DATA_W-1:0];
                        end
                        program_sequencer_pkg::MISC_SKIP_ZERO: begin
                            exec_valid_nxt = ~status_r.zero;
                        end
                        program_sequencer_pkg::MISC_SKIP_CARRY: begin
                            exec_valid_nxt = ~status_r.carry;
                        end
                        program_sequencer_pkg::MISC_CLR_ACC: begin
                            acc_nxt         = `DATA_ZERO;
                            status_nxt.zero = 1'b1;
                        end
                    endcase
                end
                program_sequencer_pkg::CLS_JUMP: begin
                    pc_nxt         = exec.target;
                    exec_valid_nxt = 1'b0;
                end
                program_sequencer_pkg::CLS_CALL: begin
                    push           = 1'b1;
                    pc_nxt         = exec.target;
                    exec_valid_nxt = 1'b0;
                end
                default: begin
                    acc_nxt = acc_r;
                end
            endcase
            // Acknowledge only after a plain instruction and with room left
            if (irq_flag_r && int_enable_in && !stack_full
                    && exec_valid_nxt) begin
                ack            = 1'b1;
                push           = 1'b1;
                pc_nxt         = `VEC_TIMER;
                exec_valid_nxt = 1'b0;
            end
        end
    end

    // ==========================================================
    // Program counter, advanced as the first phase begins
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pc_r <= `VEC_RESET;
        end else if (commit) begin
            pc_r <= pc_nxt;
        end
    end

    // ==========================================================
    // Fetch in the first phase, hand over to execute at the last
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fetch_r <= `WORD_ZERO;
        end else if (phase_r == program_sequencer_pkg::PH_T1) begin
            fetch_r <= prog_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            exec_word_r  <= `WORD_ZERO;
            exec_valid_r <= 1'b0;
        end else if (commit) begin
            exec_word_r  <= fetch_r;
            exec_valid_r <= exec_valid_nxt;
        end
    end

    // ==========================================================
    // Accumulator and status
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            acc_r    <= `DATA_ZERO;
            status_r <= '0;
        end else if (commit) begin
            acc_r    <= acc_nxt;
            status_r <= status_nxt;
        end
    end

    // ==========================================================
    // Interrupt request flag: a new request beats the clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_flag_r <= 1'b0;
        end else begin
            irq_flag_r <= (irq_flag_r & ~(ack & commit))
                        | timer_irq_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            int_ack_r <= 1'b0;
        end else begin
            int_ack_r <= ack & commit;
        end
    end

    // ==========================================================
    // Return stack
    return_stack u_return_stack (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .push_in      (push & commit),
        .pop_in       (pop & commit),
        .push_data_in (pc_r),
        .top_out      (stack_top),
        .full_out     (stack_full)
    );

    // ==========================================================
    // Outputs
    assign prog_addr_out    = pc_r;
    assign cycle_phases_out = phase_r;
    assign acc_out          = acc_r;
    assign status_out       = status_r;
    assign dummy_cycle_out  = ~exec_valid_r;
    assign irq_pending_out  = irq_flag_r;
    assign int_ack_out      = int_ack_r;
    assign stack_full_out   = stack_full;

endmodule

// ===== common/seq_map.svh
// Function
// - Four non-overlapping phases per instruction cycle
// - Counter advances at first phase; fetch then
// - Fetch overlaps execute; one instruction per cycle
// - Control transfers take two instruction cycles
// - Sequential instructions add one to counter
// - Low counter byte readable, writable; upper kept
// - Low-byte jump stays in current page
// - Low-byte write inserts one dummy cycle
// - Taken skip discards fetch; continue at plus two
// - Jump and call load eleven bits
// - Four-entry hidden return stack, hidden index
// - Call and interrupt acknowledge push return address
// - Returns pop top entry into counter
// - Reset leaves stack index at empty top
// - Full stack: latch interrupt, defer acknowledge
// - Call at full stack still executes, overflows
// - Eight-bit ALU for all data operations; clear and low-byte read load acc without it
// - ALU updates status flags and destination
// - Reset clears counter to address zero
// - Timer interrupt loads fixed vector address
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

`define PC_W        11
`define PC_ONE      11'h001
`define PC_PAGE_HI  10
`define PC_PAGE_LO  8
`define VEC_RESET   11'h000
`define VEC_TIMER   11'h008
`define WORD_W      14
`define WORD_ZERO   14'h0000
`define DATA_W      8
`define DATA_MSB    7
`define DATA_ZERO   8'h00
`define DATA_ONE    8'h01
`define STK_DEPTH   4
`define STK_IDX_W   2
`define STK_CNT_W   3
`define STK_IDX_RST 2'h0
`define STK_IDX_ONE 2'h1
`define STK_CNT_RST 3'h0
`define STK_CNT_ONE 3'h1
`define STK_CNT_MAX 3'h4
`define F_CLS_HI    13
`define F_CLS_LO    11
`define F_SUB_HI    10
`define F_SUB_LO    8
`define F_IMM_HI    7
`define F_IMM_LO    0
`define F_TGT_HI    10
`define F_TGT_LO    0

`endif

// ===== common/program_sequencer_pkg.sv
`include "seq_map.svh"
package program_sequencer_pkg;

    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } cycle_phases_t;

    typedef enum logic [2:0] {
        CLS_ALU  = 3'b000,
        CLS_MISC = 3'b001,
        CLS_JUMP = 3'b010,
        CLS_CALL = 3'b011
    } instr_class_t;

    typedef enum logic [2:0] {
        ALU_ADD = 3'b000,
        ALU_SUB = 3'b001,
        ALU_AND = 3'b010,
        ALU_OR  = 3'b011,
        ALU_XOR = 3'b100,
        ALU_RLC = 3'b101,
        ALU_INC = 3'b110,
        ALU_DEC = 3'b111
    } alu_op_t;

    typedef enum logic [2:0] {
        MISC_NOP        = 3'b000,
        MISC_SUB_RETURN = 3'b001,
        MISC_INT_RETURN = 3'b010,
        MISC_WR_PCL     = 3'b011,
        MISC_RD_PCL     = 3'b100,
        MISC_SKIP_ZERO  = 3'b101,
        MISC_SKIP_CARRY = 3'b110,
        MISC_CLR_ACC    = 3'b111
    } misc_op_t;

    typedef struct packed {
        logic carry;
        logic zero;
    } status_t;

    typedef struct packed {
        instr_class_t           cls;
        logic [2:0]             sub;
        logic [`DATA_W-1:0]     imm;
        logic [`PC_W-1:0]       target;
    } instr_fields_t;

endpackage

// ===== verilog/return_stack.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module return_stack (
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  push_in,
    input  wire logic                  pop_in,
    input  wire logic [`PC_W-1:0]      push_data_in,
    output logic      [`PC_W-1:0]      top_out,
    output logic                       full_out
);

    logic [`PC_W-1:0]      entry_r [`STK_DEPTH];
    logic [`STK_IDX_W-1:0] stack_index_r;
    logic [`STK_CNT_W-1:0] used_r;
    logic [`STK_IDX_W-1:0] top_idx;

    assign top_idx  = stack_index_r - `STK_IDX_ONE;
    assign top_out  = entry_r[top_idx];
    assign full_out = (used_r == `STK_CNT_MAX);

    // ==========================================================
    // Entries: no reset, only counter values are ever stored
    always_ff @(posedge clk_in) begin
        if (push_in) begin
            entry_r[stack_index_r] <= push_data_in;
        end
    end

    // ==========================================================
    // Index wraps, so a push at full overwrites the oldest entry
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            stack_index_r <= `STK_IDX_RST;
            used_r        <= `STK_CNT_RST;
        end else if (push_in) begin
            stack_index_r <= stack_index_r + `STK_IDX_ONE;
            if (used_r != `STK_CNT_MAX) begin
                used_r <= used_r + `STK_CNT_ONE;
            end
        end else if (pop_in) begin
            stack_index_r <= top_idx;
            if (used_r != `STK_CNT_RST) begin
                used_r <= used_r - `STK_CNT_ONE;
            end
        end
    end

endmodule

// ===== verification/seq_monitor.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module seq_monitor (
    input wire logic                                 clk_in,
    input wire logic                                 rstn_in,
    input wire logic [`WORD_W-1:0]                   prog_data_in,
    input wire logic                                 timer_irq_in,
    input wire logic                                 int_enable_in,
    input wire logic [`PC_W-1:0]                     prog_addr_out,
    input wire program_sequencer_pkg::cycle_phases_t cycle_phases_out,
    input wire logic [`DATA_W-1:0]                   acc_out,
    input wire program_sequencer_pkg::status_t       status_out,
    input wire logic                                 dummy_cycle_out,
    input wire logic                                 irq_pending_out,
    input wire logic                                 int_ack_out,
    input wire logic                                 stack_full_out
);
    logic [`WORD_W-1:0] fetch_r;
    logic [`WORD_W-1:0] exec_r;
    logic               t1;
    logic               t4;
    logic               live;
    assign t1   = cycle_phases_out == program_sequencer_pkg::PH_T1;
    assign t4   = cycle_phases_out == program_sequencer_pkg::PH_T4;
    assign live = t4 && !dummy_cycle_out;
    // ==========================================
    // Shadow of the word executing this cycle
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fetch_r <= `WORD_ZERO;
        end else if (t1) begin
            fetch_r <= prog_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            exec_r <= `WORD_ZERO;
        end else if (t4) begin
            exec_r <= fetch_r;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_phase_step: assert property (
        1'b1 |=> cycle_phases_out == 2'($past(cycle_phases_out) + 2'h1))
        else $error("phase order broken");
    a_addr_stands: assert property (
        !t1 |-> $stable(prog_addr_out)) else $error("address moved mid cycle");
    a_seq_plus_one: assert property (
        live && exec_r[13:11] == 3'b000 && !irq_pending_out && !timer_irq_in
        |=> prog_addr_out == $past(prog_addr_out) + `PC_ONE)
        else $error("counter not incremented");
    a_zero_flag: assert property (
        live && exec_r[13:11] == 3'b000 |=> status_out.zero == (acc_out == `DATA_ZERO))
        else $error("zero flag wrong");
    a_branch_load: assert property (
        live && exec_r[13:12] == 2'b01
        |=> prog_addr_out == $past(exec_r[10:0]) && dummy_cycle_out)
        else $error("branch target wrong");
    a_dummy_quiet: assert property (
        t4 && dummy_cycle_out |=> $stable(acc_out) && $stable(status_out))
        else $error("dummy cycle wrote state");
    a_full_no_ack: assert property (
        $past(stack_full_out, 2) |-> !int_ack_out) else $error("ack at full stack");
    a_ack_vector: assert property (
        $rose(int_ack_out) |-> prog_addr_out == `VEC_TIMER) else $error("vector wrong");
    a_ack_pulse: assert property (
        int_ack_out |=> !int_ack_out) else $error("ack longer than one clock");
    a_request_latch: assert property (
        timer_irq_in && int_enable_in |=> irq_pending_out || int_ack_out)
        else $error("request not latched");
endmodule

// ===== verification/prog_mem_model.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module prog_mem_model (
    input  wire logic [`PC_W-1:0]   prog_addr_in,
    input  wire logic               fire_in,
    output logic      [`WORD_W-1:0] prog_data_out,
    output logic                    timer_irq_out
);
    // ==========================================
    // Program store and timer request line
    logic [`WORD_W-1:0] mem [0:(1<<`PC_W)-1];
    assign prog_data_out = mem[prog_addr_in];
    assign timer_irq_out = fire_in;
    task automatic clear_all();
        for (int i = 0; i < (1 << `PC_W); i++) mem[i] = 14'h2000;
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module tb_top;
    logic                                 clk;
    logic                                 rstn;
    logic                                 irq_req;
    logic                                 int_en;
    logic [`WORD_W-1:0]                   word;
    logic                                 irq;
    logic [`PC_W-1:0]                     addr;
    program_sequencer_pkg::cycle_phases_t phase;
    logic [`DATA_W-1:0]                   acc;
    program_sequencer_pkg::status_t       status;
    logic                                 dummy;
    logic                                 pending;
    logic                                 ack;
    logic                                 full;
    logic                                 ack_seen;
    int                                   num_errors;
    int                                   compares;
    prog_mem_model pm (
        .prog_addr_in (addr),
        .fire_in      (irq_req),
        .prog_data_out(word),
        .timer_irq_out(irq)
    );
    program_sequencer_stack dut (
        .clk_in          (clk),
        .rstn_in         (rstn),
        .prog_data_in    (word),
        .timer_irq_in    (irq),
        .int_enable_in   (int_en),
        .prog_addr_out   (addr),
        .cycle_phases_out(phase),
        .acc_out         (acc),
        .status_out      (status),
        .dummy_cycle_out (dummy),
        .irq_pending_out (pending),
        .int_ack_out     (ack),
        .stack_full_out  (full)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            ack_seen <= 1'b1;
        end
    end
    // ==========================================
    // Helpers
    function automatic logic [13:0] w_alu(input logic [2:0] op, input logic [7:0] v);
        return {3'h0, op, v};
    endfunction
    function automatic logic [13:0] w_misc(input logic [2:0] op);
        return {3'h1, op, 8'h00};
    endfunction
    function automatic logic [13:0] w_br(input logic [2:0] cls, input logic [10:0] t);
        return {cls, t};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (phase !== program_sequencer_pkg::PH_T2 && n < 8);
    endtask
    task automatic cyc(input logic [10:0] a, input logic d);
        step();
        chk({addr, dummy}, {a, d});
    endtask
    task automatic wait_addr(input logic [10:0] a, input int lim);
        int k;
        k = 0;
        do begin
            step();
            k++;
        end while (addr !== a && k < lim);
        chk(addr, a);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        ack_seen <= 1'b0;
        pm.clear_all();
        repeat (6) @(posedge clk);
        #1;
        chk({addr, phase}, {`VEC_RESET, 2'h0});
        chk({acc, status, dummy, pending, ack, full}, 14'h0008);
    endtask
    task automatic start(input logic en);
        @(posedge clk);
        rstn <= 1'b1;
        int_en <= en;
        cyc(`VEC_RESET, 1'b1);
    endtask
    task automatic build_calls();
        for (int k = 0; k < 4; k++) pm.mem[k * 16] = w_br(3'h3, 11'((k + 1) * 16));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_alu();
        logic [2:0] op [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h6};
        logic [7:0] v [9] = '{8'h80, 8'h90, 8'h20, 8'h3C, 8'h01, 8'h31, 8'h00, 8'hFF, 8'hFE};
        logic [7:0] a;
        logic       c;
        do_reset();
        for (int i = 0; i < 9; i++) pm.mem[i] = w_alu(op[i], v[i]);
        a = 8'h00;
        c = 1'b0;
        start(1'b0);
        cyc(11'h001, 1'b0);
        for (int i = 1; i < 10; i++) begin
            cyc(11'(i + 1), 1'b0);
            case (op[i - 1])
                3'h0: {c, a} = a + v[i - 1];
                3'h1: {c, a} = {a >= v[i - 1], a - v[i - 1]};
                3'h2: a = a & v[i - 1];
                3'h3: a = a | v[i - 1];
                3'h4: a = a ^ v[i - 1];
                3'h5: {c, a} = {a, c};
                3'h6: a = a + 8'h01;
                default: a = a - 8'h01;
            endcase
            chk({acc, status}, {a, c, a == 8'h00});
        end
    endtask
    task automatic t_flow();
        logic [10:0] ad [12] = '{11'h000, 11'h001, 11'h123, 11'h124, 11'h125, 11'h126,
                                 11'h127, 11'h128, 11'h145, 11'h146, 11'h147, 11'h148};
        logic [11:0] dm = 12'h125;
        do_reset();
        pm.mem[0] = w_br(3'h2, 11'h123);
        pm.mem[11'h123] = w_alu(3'h0, 8'h00);
        pm.mem[11'h124] = w_misc(3'h5);
        pm.mem[11'h125] = w_alu(3'h0, 8'hAA);
        pm.mem[11'h126] = w_alu(3'h0, 8'h45);
        pm.mem[11'h127] = w_misc(3'h3);
        pm.mem[11'h145] = w_misc(3'h4);
        pm.mem[11'h146] = w_misc(3'h6);
        pm.mem[11'h147] = w_misc(3'h7);
        start(1'b0);
        for (int i = 1; i < 12; i++) begin
            cyc(ad[i], dm[i]);
            if (i == 8)
                chk(acc, 8'h45);
        end
        chk(acc, 8'h46);
        cyc(11'h149, 1'b0);
        chk({acc, status}, 10'h001);
    endtask
    task automatic t_stack();
        do_reset();
        build_calls();
        pm.mem[11'h040] = w_misc(3'h1);
        pm.mem[11'h031] = w_misc(3'h0);
        pm.mem[11'h032] = w_misc(3'h1);
        pm.mem[11'h021] = w_misc(3'h1);
        pm.mem[11'h011] = w_misc(3'h1);
        pm.mem[11'h008] = w_misc(3'h2);
        start(1'b1);
        wait_addr(11'h040, 20);
        chk(full, 1'b1);
        @(posedge clk);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        #1;
        chk({pending, ack}, 2'h2);
        wait_addr(11'h031, 4);
        chk(ack_seen, 1'b0);
        wait_addr(11'h008, 4);
        chk(ack_seen, 1'b1);
        wait_addr(11'h032, 4);
        wait_addr(11'h021, 4);
        wait_addr(11'h011, 4);
        wait_addr(11'h001, 4);
        chk(full, 1'b0);
    endtask
    task automatic t_over();
        do_reset();
        build_calls();
        pm.mem[11'h040] = w_br(3'h3, 11'h050);
        pm.mem[11'h050] = w_misc(3'h1);
        pm.mem[11'h041] = w_misc(3'h1);
        pm.mem[11'h031] = w_misc(3'h1);
        start(1'b0);
        @(posedge clk);
        irq_req <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        wait_addr(11'h050, 24);
        chk(full, 1'b1);
        wait_addr(11'h041, 4);
        wait_addr(11'h031, 4);
        chk(full, 1'b0);
        chk({pending, ack_seen}, 2'h2);
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        irq_req = 1'b0;
        int_en = 1'b0;
        ack_seen = 1'b0;
        num_errors = 0;
        compares = 0;
        t_alu();
        t_flow();
        t_stack();
        t_over();
        end_sim();
    end
    initial begin
        #200us;
        num_errors++;
        end_sim();
    end
endmodule
bind program_sequencer_stack seq_monitor u_mon (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .prog_data_in(prog_data_in),
    .timer_irq_in(timer_irq_in),
    .int_enable_in(int_enable_in),
    .prog_addr_out(prog_addr_out),
    .cycle_phases_out(cycle_phases_out),
    .acc_out(acc_out),
    .status_out(status_out),
    .dummy_cycle_out(dummy_cycle_out),
    .irq_pending_out(irq_pending_out),
    .int_ack_out(int_ack_out),
    .stack_full_out(stack_full_out)
);
